// file: core/rfb_rx_frame_buffer.sv
// Receive frame buffer: packs header and payload bytes into a byte FIFO
// and counts intact payload bytes for master and for slave or broadcast receptions.
// Assumes the link side presents one event per cycle at most and that
// the host reads only while the empty flag is low.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Transmitter address fills byte one, byte-two high nibble
// - Master rx stores slave address; else master address
// - Control bits go in byte-two low nibble
// - Byte three is length; payload follows
// - Master reception count kept in master register
// - Slave and broadcast counts in slave register
// - Count only error-free payload bytes
// - Forty-byte FIFO holds all reception frames
module rfb_rx_frame_buffer #(
    parameter int DEPTH = rfb_pkg::FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic                 i_clk,
    input  wire logic                 i_reset,
    // Link side
    input  wire logic                 i_hdr_valid,
    input  wire rfb_pkg::rfb_header_t i_hdr,
    input  wire logic                 i_pay_valid,
    input  wire rfb_pkg::rfb_payload_t i_pay,
    output logic                      o_hdr_ready,
    // Host side
    input  wire logic                 i_rd,
    output logic [7:0]                o_rx_fifo_data,
    output logic                      o_rx_fifo_empty_flag,
    output logic                      o_rx_fifo_full,
    output logic [7:0]                o_master_rx_byte_count,
    output logic [7:0]                o_slave_rx_byte_count
);

    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    // ============================================================
    // Storage and state
    typedef enum logic [1:0] {RFB_IDLE, RFB_B2, RFB_B3, RFB_PAY} rfb_state_t;

    logic [7:0]           mem [DEPTH];
    logic [PW-1:0]        wr_ptr;
    logic [PW-1:0]        rd_ptr;
    logic [CW-1:0]        fill;
    rfb_state_t           state;
    rfb_pkg::rfb_header_t hdr;
    logic [7:0]           mcount;
    logic [7:0]           scount;

    logic [PW-1:0]        next_wr_ptr;
    logic [PW-1:0]        next_rd_ptr;
    logic [CW-1:0]        next_fill;
    rfb_state_t           next_state;
    rfb_pkg::rfb_header_t next_hdr;
    logic [7:0]           next_mcount;
    logic [7:0]           next_scount;
    logic                 wr_en;
    logic [7:0]           wr_byte;
    logic                 rd_en;
    logic                 full;
    logic [7:0]           next_data;
    logic                 next_empty;
    logic                 next_full;
    logic                 next_hdr_ready;

    assign full = (fill == CW'(DEPTH));

    // ============================================================
    // Next-state logic
    always_comb begin
        next_state  = state;
        next_hdr    = hdr;
        next_mcount = mcount;
        next_scount = scount;
        wr_en       = 1'b0;
        wr_byte     = 8'h00;
        case (state)
            RFB_IDLE: begin
                if (i_hdr_valid && !full) begin
                    next_hdr = i_hdr;
                    wr_en    = 1'b1;
                    wr_byte  = i_hdr.xmit_addr[11:4];
                    next_state = RFB_B2;
                    if (i_hdr.kind == rfb_pkg::RFB_KIND_MASTER) begin
                        next_mcount = rfb_pkg::COUNT_RESET;
                    end else begin
                        next_scount = rfb_pkg::COUNT_RESET;
                    end
                end
            end
            RFB_B2: begin
                if (!full) begin
                    wr_en      = 1'b1;
                    wr_byte    = {hdr.xmit_addr[3:0], hdr.control};
                    next_state = RFB_B3;
                end
            end
            RFB_B3: begin
                if (!full) begin
                    wr_en      = 1'b1;
                    wr_byte    = hdr.data_length;
                    next_state = RFB_PAY;
                end
            end
            RFB_PAY: begin
                // Payload ends by a new header; a byte lost to a full FIFO is not counted
                if (i_hdr_valid) begin
                    next_state = RFB_IDLE;
                end else if (i_pay_valid && !i_pay.error && !full) begin
                    wr_en   = 1'b1;
                    wr_byte = i_pay.data;
                    if (hdr.kind == rfb_pkg::RFB_KIND_MASTER) begin
                        next_mcount = mcount + 8'h01;
                    end else begin
                        next_scount = scount + 8'h01;
                    end
                end
            end
            default: next_state = RFB_IDLE;
        endcase
    end

    // ============================================================
    // FIFO pointers and fill
    // A fill counter, not a pointer compare, keeps full and empty exact
    // Pointers wrap by compare, since the depth need not be a power of two
    always_comb begin
        // Empty reads are dropped, so a misbehaving host cannot underflow
        rd_en = i_rd && (fill != '0);
        if (wr_en) begin
            next_wr_ptr = (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + PW'(1);
        end else begin
            next_wr_ptr = wr_ptr;
        end
        if (rd_en) begin
            next_rd_ptr = (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + PW'(1);
        end else begin
            next_rd_ptr = rd_ptr;
        end
        next_fill = fill + CW'(wr_en) - CW'(rd_en);
    end

    // ============================================================
    // Host- and link-facing output values
    always_comb begin
        // Data shows the byte at the head after this cycle's updates;
        // a byte written into an empty FIFO bypasses storage to the head
        if (wr_en && next_fill == CW'(1)) begin
            next_data = wr_byte;
        end else begin
            next_data = mem[next_rd_ptr];
        end
        next_empty = (next_fill == '0);
        next_full  = (next_fill == CW'(DEPTH));
        // Ready is registered, so it looks at the state after this edge
        next_hdr_ready = (next_state == RFB_IDLE || next_state == RFB_PAY) && !next_full;
    end

    // ============================================================
    // Frame state registers
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            state  <= RFB_IDLE;
            hdr    <= '0;
            mcount <= rfb_pkg::COUNT_RESET;
            scount <= rfb_pkg::COUNT_RESET;
        end else begin
            // Header is kept for bytes two and three and for the count choice
            state  <= next_state;
            hdr    <= next_hdr;
            mcount <= next_mcount;
            scount <= next_scount;
        end
    end

    // ============================================================
    // FIFO pointer registers
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            fill   <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            fill   <= next_fill;
        end
    end

    // ============================================================
    // Output registers; every output leaves straight from a flip-flop
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_rx_fifo_data         <= 8'h00;
            o_rx_fifo_empty_flag   <= 1'b1;
            o_rx_fifo_full         <= 1'b0;
            o_hdr_ready            <= 1'b0;
            o_master_rx_byte_count <= rfb_pkg::COUNT_RESET;
            o_slave_rx_byte_count  <= rfb_pkg::COUNT_RESET;
        end else begin
            o_rx_fifo_data         <= next_data;
            o_rx_fifo_empty_flag   <= next_empty;
            o_rx_fifo_full         <= next_full;
            o_hdr_ready            <= next_hdr_ready;
            o_master_rx_byte_count <= next_mcount;
            o_slave_rx_byte_count  <= next_scount;
        end
    end

    // Storage has no reset; contents are undefined until written
    always_ff @(posedge i_clk) begin
        if (wr_en) begin
            mem[wr_ptr] <= wr_byte;
        end
    end

endmodule : rfb_rx_frame_buffer

`default_nettype wire

// file: core/rfb_pkg.sv
// Package for the receive frame buffer readout block.
// Assumes a single 125 MHz clock domain and a synchronous reset.
package rfb_pkg;

    // ============================================================
    // Buffer geometry and reset values
    localparam int          FIFO_DEPTH  = 40;
    localparam int          BYTE_W      = 8;
    localparam int          ADDR_W      = 12;
    localparam int          CTRL_W      = 4;
    localparam logic [7:0]  COUNT_RESET = 8'h00;

    // ============================================================
    // Reception kinds
    typedef enum logic [1:0] {
        RFB_KIND_MASTER,
        RFB_KIND_SLAVE,
        RFB_KIND_BROADCAST
    } rfb_kind_t;

    // Frame header handed over by the link side at frame start
    typedef struct packed {
        rfb_kind_t          kind;
        logic [ADDR_W-1:0]  xmit_addr;
        logic [CTRL_W-1:0]  control;
        logic [7:0]         data_length;
    } rfb_header_t;

    // One received payload byte with its error status
    typedef struct packed {
        logic [7:0] data;
        logic       error;
    } rfb_payload_t;

endpackage : rfb_pkg

// file: verification/rfb_host_model.sv
// Host reader model: pulls bytes from the receive FIFO.
// Assumes one clock; strobes change just after the falling edge.
`timescale 1ns/1ps
`default_nettype none
module rfb_host_model (
    input  wire logic       i_clk,
    input  wire logic       i_go,
    input  wire logic       i_empty,
    input  wire logic [7:0] i_data,
    output logic            o_rd,
    output logic [7:0]      o_byte
);
    initial o_rd = 1'b0;
    initial o_byte = 8'h00;
    // Head byte is latched with the strobe, ready for the reading edge
    always @(negedge i_clk) begin
        o_rd <= i_go && !i_empty;
        o_byte <= i_data;
    end
endmodule : rfb_host_model
`default_nettype wire

// file: verification/rfb_props.sv
// Port checker for the receive frame buffer.
// Bound from the bench top; sees the top module's ports only.
`timescale 1ns/1ps
`default_nettype none
module rfb_props (
    input wire logic i_clk, i_reset, i_hdr_valid, i_pay_valid, i_rd, o_hdr_ready,
    input wire rfb_pkg::rfb_payload_t i_pay,
    input wire logic o_rx_fifo_empty_flag, o_rx_fifo_full,
    input wire logic [7:0] o_rx_fifo_data, o_master_rx_byte_count, o_slave_rx_byte_count
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_reset);
    logic quiet;
    logic [7:0] m, s;
    assign quiet = !i_hdr_valid && !i_pay_valid;
    assign m = o_master_rx_byte_count;
    assign s = o_slave_rx_byte_count;
    // Long enough for pending header bytes to land
    sequence s_idle_empty; (o_rx_fifo_empty_flag && quiet)[*4]; endsequence
    sequence s_idle_held; (!i_rd && !o_rx_fifo_empty_flag && quiet)[*3]; endsequence
    // Reset values first, then ready one edge after release
    sequence s_reset_view;
        o_rx_fifo_empty_flag && !o_rx_fifo_full && m == 8'h00 && s == 8'h00 && !o_hdr_ready
        ##1 o_hdr_ready;
    endsequence
    rst_clear_a: assert property ($fell(i_reset) |-> s_reset_view)
        else $error("bad reset");
    flags_excl_a: assert property (!(o_rx_fifo_full && o_rx_fifo_empty_flag))
        else $error("full and empty");
    full_ready_a: assert property (o_rx_fifo_full |-> !o_hdr_ready)
        else $error("ready on full");
    cnt_hold_a: assert property (quiet |=> $stable(m) && $stable(s))
        else $error("count moved");
    cnt_err_a: assert property (!i_hdr_valid && i_pay_valid && i_pay.error
        |=> $stable(m) && $stable(s)) else $error("bad byte counted");
    cnt_step_a: assert property (!i_hdr_valid |=> m + s == $past(m) + $past(s)
        || m + s == $past(m) + $past(s) + 8'h01) else $error("count step");
    empty_hold_a: assert property (s_idle_empty |=> o_rx_fifo_empty_flag)
        else $error("empty lost");
    head_hold_a: assert property (s_idle_held
        |=> $stable(o_rx_fifo_data) && !o_rx_fifo_empty_flag) else $error("head moved");
endmodule : rfb_props
`default_nettype wire

// file: verification/rx_frame_buffer_readout_test.sv
// Self-checking bench: queue model of the FIFO and counts.
// Assumes the host model and checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module rx_frame_buffer_readout_test;
    logic i_clk = 1'b0, i_reset = 1'b1, hv = 1'b0, pv = 1'b0, go = 1'b0, rd, rdy, emp, full;
    rfb_pkg::rfb_header_t  hdr = '0;
    rfb_pkg::rfb_payload_t pay = '0;
    logic [7:0] dat, mc, sc, hb;
    int         bad_count = 0, compares = 0, seed = 97, cyc = 0, em = 0, es = 0;
    logic [7:0] q[$];
    always #4 i_clk = ~i_clk;
    rfb_rx_frame_buffer u_dut (.i_clk, .i_reset, .i_hdr_valid(hv), .i_hdr(hdr), .i_pay_valid(pv),
        .i_pay(pay), .o_hdr_ready(rdy), .i_rd(rd), .o_rx_fifo_data(dat),
        .o_rx_fifo_empty_flag(emp), .o_rx_fifo_full(full), .o_master_rx_byte_count(mc),
        .o_slave_rx_byte_count(sc));
    rfb_host_model u_host (.i_clk, .i_go(go), .i_empty(emp), .i_data(dat), .o_rd(rd), .o_byte(hb));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic chk_count(input logic [7:0] got, input int exp);
        chk(got, 8'(exp));
    endtask : chk_count
    task automatic chk_flag(input logic got, input logic exp);
        chk({7'h00, got}, {7'h00, exp});
    endtask : chk_flag
    task automatic print_verdict;
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : print_verdict
    task automatic frame(input int k, input int len, input int bad, input bit first);
        int n;
        logic [11:0] a;
        logic [3:0] c;
        logic [7:0] d;
        n = 0;
        // A header pulse in the payload state only closes the open frame
        if (!first) begin
            hv <= 1'b1;
            @(negedge i_clk);
        end
        while (!rdy && n < 500) begin
            hv <= 1'b0;
            @(negedge i_clk);
            n++;
        end
        a = 12'($random(seed));
        c = 4'($random(seed));
        hdr <= '{rfb_pkg::rfb_kind_t'(k), a, c, len[7:0]};
        hv <= 1'b1;
        q.push_back(a[11:4]);
        q.push_back({a[3:0], c});
        q.push_back(len[7:0]);
        if (k == 0) em = 0; else es = 0;
        @(negedge i_clk) hv <= 1'b0;
        repeat (3) @(negedge i_clk);
        for (int i = 0; i < len; i++) begin
            d = 8'($random(seed));
            pay <= '{d, i == bad};
            pv <= 1'b1;
            // A byte that meets a full FIFO is lost and not counted
            if (i != bad && q.size() < rfb_pkg::FIFO_DEPTH) begin
                q.push_back(d);
                if (k == 0) em++;
                else es++;
            end
            @(negedge i_clk);
        end
        pv <= 1'b0;
        @(negedge i_clk);
        chk_count(mc, em);
        chk_count(sc, es);
    endtask : frame
    always @(posedge i_clk) if (rd) chk(hb, q.pop_front());
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 20000) begin bad_count++; print_verdict(); end
    end
    initial begin
        repeat (10) @(negedge i_clk);
        i_reset <= 1'b0;
        repeat (2) @(negedge i_clk);
        go <= 1'b1;
        for (int k = 0; k < 3; k++) frame(k, 3 + k, k, k == 0);
        repeat (30) @(negedge i_clk);
        go <= 1'b0;
        frame(1, 45, 2, 0);
        chk_flag(full, 1'b1);
        // Host held off so the head byte has to stand for several cycles
        repeat (4) @(negedge i_clk);
        chk(dat, q[0]);
        chk_flag(emp, 1'b0);
        go <= 1'b1;
        repeat (80) @(negedge i_clk);
        chk_flag(emp, 1'b1);
        chk_count(8'(q.size()), 0);
        print_verdict();
    end
endmodule : rx_frame_buffer_readout_test
bind rfb_rx_frame_buffer rfb_props u_props (.i_clk, .i_reset, .i_hdr_valid, .i_pay_valid, .i_rd,
    .o_hdr_ready, .i_pay, .o_rx_fifo_empty_flag, .o_rx_fifo_full, .o_rx_fifo_data,
    .o_master_rx_byte_count, .o_slave_rx_byte_count);
`default_nettype wire
